// >>> core/mrs_defines.vh
// constants of the motion record select parameter block
// Summary of operation
// - status bits 0-5 show executing record
// - 64 records; only index bits 0-5 used
// - index reads zero unless program runs in program submode
// - reserved bits carry no function
// - status bit 15 one: direct-entry inputs used
// - bit 15 zero: start record from bits 0-5
// - acceleration word scales max, FFFFh full
// - deceleration word scales max, FFFFh full
// - limiting off: bit 0 absolute else relative
// - limiting on: bit 0 absolute else offset
// - per-record bit 0 absolute else relative
// - per-record, limiting on: absolute else offset
// - range designation values 0 to 3
// - direct-entry request deferred while program runs
`ifndef MRS_DEFINES_VH
`define MRS_DEFINES_VH

// ---------------------------------------------------------------
// parameter numbers
// ---------------------------------------------------------------
`define MRS_PN_RANGE          16'h2400
`define MRS_PN_STATUS         16'h2533
`define MRS_PN_ACCEL          16'h2536
`define MRS_PN_DECEL          16'h2537
`define MRS_PN_MODE           16'h2538
`define MRS_PN_TABLE          16'h2610

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define MRS_RST_RANGE_DESIG   2'h0
`define MRS_RST_ACCEL_SCALE   16'h0000
`define MRS_RST_DECEL_SCALE   16'h0000
`define MRS_RST_TARGET_MODE   1'h0
`define MRS_RST_TASK_MODE     1'h0

// ---------------------------------------------------------------
// field positions and limits
// ---------------------------------------------------------------
`define MRS_SUBMODE_BIT       15
`define MRS_INDEX_MSB         5
`define MRS_INDEX_FIELD_MSB   9
`define MRS_RECORDS           64
`define MRS_RANGE_DESIG_MAX   32'h0000_0003
`define MRS_TASK_MODE_MAX     32'h0000_0001
`define MRS_FULL_SCALE        16'hFFFF

// ---------------------------------------------------------------
// range designation values
// ---------------------------------------------------------------
`define MRS_RANGE_OFF         2'h0
`define MRS_RANGE_SHORTEST    2'h1
`define MRS_RANGE_POSITIVE    2'h2
`define MRS_RANGE_NEGATIVE    2'h3

// ---------------------------------------------------------------
// target interpretation codes
// ---------------------------------------------------------------
`define MRS_KIND_RELATIVE     2'h0
`define MRS_KIND_ABSOLUTE     2'h1
`define MRS_KIND_OFFSET       2'h2
`define MRS_KIND_ABS_RANGE    2'h3

`endif

// >>> core/mrs_submode.v
// submode switch between program and direct entry
`timescale 1ns/1ns
`include "mrs_defines.vh"

module mrs_submode (
  input  wire clk,
  input  wire rst,
  input  wire direct_request,
  input  wire prog_running,
  input  wire prog_terminate,
  input  wire cmd_busy,
  output reg  direct_entry_submode,
  output reg  direct_reject
);

  // ---------------------------------------------------------------
  // switch state
  // ---------------------------------------------------------------
  // entry waits for the program to end; leaving is immediate and
  // rejects a direct command that is still being executed
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      direct_entry_submode <= 1'b0;
      direct_reject        <= 1'b0;
    end else begin
      direct_reject <= 1'b0;
      if (direct_request) begin
        // enter only once the program has ended or is terminated
        if (!prog_running || prog_terminate) begin
          direct_entry_submode <= 1'b1;
        end
      end else begin
        // leave at once, reject a running direct command
        if (direct_entry_submode && cmd_busy) begin
          direct_reject <= 1'b1;
        end
        direct_entry_submode <= 1'b0;
      end
    end
  end

endmodule

// >>> core/mrs_task_table.v
// per-record task mode table, bit 0 of each entry held
`timescale 1ns/1ns
`include "mrs_defines.vh"

module mrs_task_table (
  input  wire       clk,
  input  wire       rst,
  input  wire       wr_en,
  input  wire [5:0] wr_idx,
  input  wire       wr_bit,
  input  wire [5:0] rd_idx,
  output wire       rd_bit,
  input  wire [5:0] look_idx,
  output wire       look_bit
);

  // one absolute flag per record; reserved bits are not stored
  reg [`MRS_RECORDS-1:0] abs_flag;

  // ---------------------------------------------------------------
  // entry storage
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `MRS_RECORDS; g = g + 1) begin : entry
      // each entry loads only when addressed
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          abs_flag[g] <= `MRS_RST_TASK_MODE;
        end else if (wr_en && (wr_idx == g)) begin
          abs_flag[g] <= wr_bit;
        end
      end
    end
  endgenerate

  // parameter read port and command lookup port
  assign rd_bit   = abs_flag[rd_idx];
  assign look_bit = abs_flag[look_idx];

endmodule

// >>> core/mrs_regs.v
// motion record select parameter block, top level
`timescale 1ns/1ns
`include "mrs_defines.vh"

module mrs_regs (
  input  wire        clk,
  input  wire        rst,
  // parameter channel
  input  wire        par_rd,
  input  wire        par_wr,
  input  wire [15:0] parameter_number,
  input  wire [5:0]  par_subindex,
  input  wire [31:0] par_wdata,
  output reg  [31:0] par_rdata,
  output reg         par_ack,
  output reg         par_err,
  // cyclic process words
  input  wire [15:0] record_selection_word,
  input  wire [31:0] direct_target_position,
  input  wire [31:0] direct_velocity,
  output reg  [15:0] active_record_status,
  // path interpolator side
  input  wire        prog_running,
  input  wire        prog_terminate,
  input  wire [9:0]  exec_record,
  input  wire        record_advance,
  input  wire        motion_start,
  input  wire        cmd_busy,
  input  wire [31:0] max_accel,
  input  wire [31:0] max_decel,
  // latched motion command
  output reg         cmd_valid,
  output reg         cmd_direct,
  output reg  [5:0]  cmd_record,
  output reg  [1:0]  cmd_kind,
  output reg  [1:0]  cmd_range_mode,
  output reg  [31:0] cmd_target,
  output reg  [31:0] cmd_velocity,
  output reg  [31:0] cmd_accel,
  output reg  [31:0] cmd_decel,
  output wire        cmd_reject
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  reg  [1:0]  range_desig;       // range limit designation
  reg  [15:0] direct_accel_scale; // normalized acceleration
  reg  [15:0] direct_decel_scale; // normalized deceleration
  reg         direct_target_mode; // bit 0 of the mode word

  // ---------------------------------------------------------------
  // internal nets
  // ---------------------------------------------------------------
  wire        direct_entry_submode; // submode in force
  wire        tbl_wr;               // table write strobe
  wire        tbl_rd_bit;           // table read data
  wire        tbl_look_bit;         // table lookup for command
  wire [5:0]  look_idx;             // record looked up
  wire        range_on;             // range limiting active
  wire        is_table;             // table parameter addressed
  wire [15:0] next_status;          // status word to publish
  reg         wr_ok;                // write accepted
  reg         known;                // parameter exists
  reg  [31:0] next_rdata;           // read data mux

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // target interpretation from an absolute flag and range setting
  function [1:0] mrs_kind;
    input abs_bit;
    input limit_on;
    begin
      if (limit_on) begin
        // in-range absolute target or offset from last target
        mrs_kind = abs_bit ? `MRS_KIND_ABS_RANGE : `MRS_KIND_OFFSET;
      end else begin
        // plain absolute or relative to actual position
        mrs_kind = abs_bit ? `MRS_KIND_ABSOLUTE : `MRS_KIND_RELATIVE;
      end
    end
  endfunction

  // scales a maximum by a fraction where full scale means 100 %
  function [31:0] mrs_scale;
    input [31:0] max_val;
    input [15:0] frac;
    reg   [47:0] prod;
    begin
      prod = 48'h0;

      // adding one max makes full scale return max exactly
      prod = ({16'h0000, max_val} * {32'h0000_0000, frac})
           + {16'h0000, max_val};
      if (frac == 16'h0000) begin
        mrs_scale = 32'h0000_0000;
      end else begin
        mrs_scale = prod[47:16];
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // submode switch
  // ---------------------------------------------------------------
  // the controller asks with the top bit of the selection word
  mrs_submode u_submode (
    .clk                  (clk),
    .rst                  (rst),
    .direct_request       (record_selection_word[`MRS_SUBMODE_BIT]),
    .prog_running         (prog_running),
    .prog_terminate       (prog_terminate),
    .cmd_busy             (cmd_busy),
    .direct_entry_submode (direct_entry_submode),
    .direct_reject        (cmd_reject)
  );

  // ---------------------------------------------------------------
  // task mode table
  // ---------------------------------------------------------------
  assign is_table = (parameter_number == `MRS_PN_TABLE);
  assign tbl_wr   = par_wr && is_table
                 && (par_wdata <= `MRS_TASK_MODE_MAX);

  // a start looks up the selected record, a step the executing one
  assign look_idx = motion_start
                  ? record_selection_word[`MRS_INDEX_MSB:0]
                  : exec_record[`MRS_INDEX_MSB:0];

  mrs_task_table u_table (
    .clk      (clk),
    .rst      (rst),
    .wr_en    (tbl_wr),
    .wr_idx   (par_subindex),
    .wr_bit   (par_wdata[0]),
    .rd_idx   (par_subindex),
    .rd_bit   (tbl_rd_bit),
    .look_idx (look_idx),
    .look_bit (tbl_look_bit)
  );

  assign range_on = (range_desig != `MRS_RANGE_OFF);

  // ---------------------------------------------------------------
  // parameter decode
  // ---------------------------------------------------------------
  // picks read data and checks writes for access and range
  always @* begin
    known      = 1'b1;
    wr_ok      = 1'b0;
    next_rdata = 32'h0000_0000;

    if (parameter_number == `MRS_PN_RANGE) begin
      // designations above 3 refused
      next_rdata = {30'h0, range_desig};
      wr_ok      = (par_wdata <= `MRS_RANGE_DESIG_MAX);
    end else if (parameter_number == `MRS_PN_STATUS) begin
      // read only; writes refused
      next_rdata = {16'h0000, active_record_status};
      wr_ok      = 1'b0;
    end else if (parameter_number == `MRS_PN_ACCEL) begin
      // upper half must be zero
      next_rdata = {16'h0000, direct_accel_scale};
      wr_ok      = (par_wdata[31:16] == 16'h0000);
    end else if (parameter_number == `MRS_PN_DECEL) begin
      next_rdata = {16'h0000, direct_decel_scale};
      wr_ok      = (par_wdata[31:16] == 16'h0000);
    end else if (parameter_number == `MRS_PN_MODE) begin
      // only bit 0 exists; reserved bits read zero
      next_rdata = {31'h0, direct_target_mode};
      wr_ok      = (par_wdata[31:16] == 16'h0000);
    end else if (is_table) begin
      // reserved entry bits read zero
      next_rdata = {31'h0, tbl_rd_bit};
      wr_ok      = (par_wdata <= `MRS_TASK_MODE_MAX);
    end else begin
      // unknown parameter number
      known = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // writable parameters
  // ---------------------------------------------------------------
  // stored on an accepted write; reserved bits are dropped
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      range_desig        <= `MRS_RST_RANGE_DESIG;
      direct_accel_scale <= `MRS_RST_ACCEL_SCALE;
      direct_decel_scale <= `MRS_RST_DECEL_SCALE;
      direct_target_mode <= `MRS_RST_TARGET_MODE;
    end else if (par_wr && wr_ok) begin
      if (parameter_number == `MRS_PN_RANGE) begin
        range_desig <= par_wdata[1:0];
      end else if (parameter_number == `MRS_PN_ACCEL) begin
        direct_accel_scale <= par_wdata[15:0];
      end else if (parameter_number == `MRS_PN_DECEL) begin
        direct_decel_scale <= par_wdata[15:0];
      end else if (parameter_number == `MRS_PN_MODE) begin
        direct_target_mode <= par_wdata[0];
      end
    end
  end

  // ---------------------------------------------------------------
  // parameter answer
  // ---------------------------------------------------------------
  // one-cycle acknowledge with error flag and read data
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      par_ack   <= 1'b0;
      par_err   <= 1'b0;
      par_rdata <= 32'h0000_0000;
    end else begin
      par_ack <= par_rd || par_wr;

      if (par_rd || par_wr) begin
        // refused write or unknown number flags an error
        par_err   <= !known || (par_wr && !wr_ok);
        par_rdata <= par_rd ? next_rdata : 32'h0000_0000;
      end else begin
        par_err <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // active record status
  // ---------------------------------------------------------------
  // index only while a program runs in program submode
  assign next_status[`MRS_SUBMODE_BIT] = direct_entry_submode;
  assign next_status[14:10] = 5'h00;
  assign next_status[`MRS_INDEX_FIELD_MSB:6] = 4'h0;

  assign next_status[`MRS_INDEX_MSB:0] =
    (!direct_entry_submode && prog_running)
    ? exec_record[`MRS_INDEX_MSB:0]
    : 6'h00;

  // status word leaves from a flip-flop
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      active_record_status <= 16'h0000;
    end else begin
      active_record_status <= next_status;
    end
  end

  // ---------------------------------------------------------------
  // motion command latch
  // ---------------------------------------------------------------
  // a direct-entry start samples all inputs so later changes wait for the next
  // command; a record step in a program updates the record and its
  // interpretation only
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_valid      <= 1'b0;
      cmd_direct     <= 1'b0;
      cmd_record     <= 6'h00;
      cmd_kind       <= `MRS_KIND_RELATIVE;
      cmd_range_mode <= `MRS_RANGE_OFF;
      cmd_target     <= 32'h0000_0000;
      cmd_velocity   <= 32'h0000_0000;
      cmd_accel      <= 32'h0000_0000;
      cmd_decel      <= 32'h0000_0000;
    end else begin
      cmd_valid <= 1'b0;

      if (motion_start) begin
        cmd_valid      <= 1'b1;
        cmd_direct     <= direct_entry_submode;
        cmd_range_mode <= range_desig;

        if (direct_entry_submode) begin
          // direct entry: words sampled now
          cmd_record   <= 6'h00;
          cmd_kind     <= mrs_kind(direct_target_mode,
                                   range_on);
          cmd_target   <= direct_target_position;
          cmd_velocity <= direct_velocity;
          cmd_accel    <= mrs_scale(max_accel,
                                    direct_accel_scale);
          cmd_decel    <= mrs_scale(max_decel,
                                    direct_decel_scale);
        end else begin
          // program: start record from the selection word
          cmd_record <= record_selection_word[`MRS_INDEX_MSB:0];
          cmd_kind   <= mrs_kind(tbl_look_bit, range_on);
        end
      end else if (record_advance && !cmd_direct) begin
        // next record of a running program
        cmd_valid  <= 1'b1;
        cmd_record <= exec_record[`MRS_INDEX_MSB:0];
        cmd_kind   <= mrs_kind(tbl_look_bit, range_on);
      end
    end
  end

endmodule

// >>> tb/mrs_regs_assertions.sv
// concurrent checks on the ports of the motion record select block
`timescale 1ns/1ns

module mrs_regs_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        par_wr,
  input wire logic [15:0] parameter_number,
  input wire logic [31:0] par_wdata,
  input wire logic        par_ack,
  input wire logic        par_err,
  input wire logic [15:0] record_selection_word,
  input wire logic [15:0] active_record_status,
  input wire logic        prog_running,
  input wire logic        prog_terminate,
  input wire logic [9:0]  exec_record,
  input wire logic        motion_start,
  input wire logic        cmd_busy,
  input wire logic        cmd_valid,
  input wire logic        cmd_direct,
  input wire logic [5:0]  cmd_record,
  input wire logic        cmd_reject
);
  // -------------------------------------------------------------
  // one clock domain, all checks off during reset
  // -------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_ro_write;
    par_wr && parameter_number == 16'h2533 |=> par_ack && par_err;
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("status write not refused");
  property p_range_val;
    par_wr && parameter_number == 16'h2400 && par_wdata > 32'h0000_0003
      |=> par_ack && par_err;
  endproperty
  a_range_val: assert property (p_range_val)
    else $error("range designation above 3 taken");
  property p_status_rec;
    !active_record_status[15] && $past(prog_running)
      |-> active_record_status[5:0] == $past(exec_record[5:0]);
  endproperty
  a_status_rec: assert property (p_status_rec)
    else $error("status record differs from executed record");
  property p_idle_zero;
    !prog_running |=> active_record_status[5:0] == 6'h00;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("record shown with no program running");
  property p_direct_zero;
    active_record_status[15] |-> active_record_status[5:0] == 6'h00;
  endproperty
  a_direct_zero: assert property (p_direct_zero)
    else $error("record shown in direct entry");
  property p_reserved;
    active_record_status[14:6] == 9'h000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("status bits 6 to 14 not zero");
  property p_enter;
    record_selection_word[15] && !prog_running
      |-> ##2 active_record_status[15];
  endproperty
  a_enter: assert property (p_enter)
    else $error("direct entry not entered while idle");
  property p_defer;
    prog_running && !prog_terminate ##1 !active_record_status[15]
      |=> !active_record_status[15];
  endproperty
  a_defer: assert property (p_defer)
    else $error("direct entry entered while program ran");
  property p_leave;
    !record_selection_word[15] |-> ##2 !active_record_status[15];
  endproperty
  a_leave: assert property (p_leave)
    else $error("program submode not resumed");
  property p_start;
    motion_start |=> cmd_valid;
  endproperty
  a_start: assert property (p_start)
    else $error("motion start not latched");
  property p_reject;
    cmd_reject |-> active_record_status[15] && $past(cmd_busy)
      && !$past(record_selection_word[15]);
  endproperty
  a_reject: assert property (p_reject)
    else $error("reject without busy direct command");
  property p_direct_rec;
    cmd_valid && cmd_direct |-> cmd_record == 6'h00;
  endproperty
  a_direct_rec: assert property (p_direct_rec)
    else $error("direct command carries a record");

  c_direct: cover property (cmd_valid && cmd_direct);
  c_reject: cover property (cmd_reject);
  c_refuse: cover property (par_ack && par_err);
endmodule

// >>> tb/mrs_fieldbus_ctrl.sv
// fieldbus controller model sending the cyclic process words
`timescale 1ns/1ns

module mrs_fieldbus_ctrl (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        want_direct,
  input  wire logic [5:0]  want_record,
  input  wire logic [31:0] want_target,
  input  wire logic [31:0] want_velocity,
  output logic      [15:0] record_selection_word,
  output logic      [31:0] direct_target_position,
  output logic      [31:0] direct_velocity
);
  // words go out once per bus cycle, so a change lands one edge late
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      record_selection_word  <= 16'h0000;
      direct_target_position <= 32'h0000_0000;
      direct_velocity        <= 32'h0000_0000;
    end else begin
      // bit 15 asks for direct entry, reserved bits go out as zero
      record_selection_word  <= {want_direct, 9'h000, want_record};
      direct_target_position <= want_target;
      direct_velocity        <= want_velocity;
    end
  end
endmodule

// >>> tb/mrs_regs_tb.sv
// self-checking bench for the motion record select block
`timescale 1ns/1ns
`define CHK(x, y) begin \
  check_count++; \
  if ((x) !== (y)) begin \
    mismatches++; \
    $display("wrong value at %0t: %h not %h", $time, x, y); \
  end \
end

module mrs_regs_tb;
  logic         clk = 1'b0, rst = 1'b1, par_rd = 1'b0, par_wr = 1'b0;
  logic [15:0]  parameter_number = 16'h0000;
  logic [5:0]   par_subindex = 6'h00, want_record = 6'h00;
  logic [31:0]  par_wdata = 32'h0, want_target = 32'h0, want_velocity = 32'h0;
  logic         prog_running = 1'b0, prog_terminate = 1'b0, want_direct = 1'b0;
  logic [9:0]   exec_record = 10'h000;
  logic         record_advance = 1'b0, motion_start = 1'b0, cmd_busy = 1'b0;
  logic [31:0]  max_accel = 32'h0, max_decel = 32'h0;
  logic [31:0]  par_rdata, direct_target_position, direct_velocity;
  logic [31:0]  cmd_target, cmd_velocity, cmd_accel, cmd_decel;
  logic [15:0]  record_selection_word, active_record_status, a, d;
  logic         par_ack, par_err, cmd_valid, cmd_direct, cmd_reject;
  logic [5:0]   cmd_record;
  logic [1:0]   cmd_kind, cmd_range_mode, k;
  logic [15:0]  rnd = 16'h0024;
  logic [32:0]  pq[$], pe;
  logic [138:0] cq[$], ce;
  logic [15:0]  pn[6] = '{16'h2400, 16'h2536, 16'h2537, 16'h2538,
                          16'h2610, 16'h2533};
  int           mismatches = 0, check_count = 0, cyc = 0;

  mrs_regs u_mrs_regs (
    .clk(clk), .rst(rst), .par_rd(par_rd), .par_wr(par_wr),
    .parameter_number(parameter_number), .par_subindex(par_subindex),
    .par_wdata(par_wdata), .par_rdata(par_rdata), .par_ack(par_ack),
    .par_err(par_err), .record_selection_word(record_selection_word),
    .direct_target_position(direct_target_position),
    .direct_velocity(direct_velocity),
    .active_record_status(active_record_status),
    .prog_running(prog_running), .prog_terminate(prog_terminate),
    .exec_record(exec_record), .record_advance(record_advance),
    .motion_start(motion_start), .cmd_busy(cmd_busy),
    .max_accel(max_accel), .max_decel(max_decel), .cmd_valid(cmd_valid),
    .cmd_direct(cmd_direct), .cmd_record(cmd_record), .cmd_kind(cmd_kind),
    .cmd_range_mode(cmd_range_mode), .cmd_target(cmd_target),
    .cmd_velocity(cmd_velocity), .cmd_accel(cmd_accel),
    .cmd_decel(cmd_decel), .cmd_reject(cmd_reject)
  );

  mrs_fieldbus_ctrl u_mrs_fieldbus_ctrl (
    .clk(clk), .rst(rst), .want_direct(want_direct),
    .want_record(want_record), .want_target(want_target),
    .want_velocity(want_velocity),
    .record_selection_word(record_selection_word),
    .direct_target_position(direct_target_position),
    .direct_velocity(direct_velocity)
  );

  always #20 clk = ~clk;

  // pseudo-random step
  function automatic [15:0] nx(input logic [15:0] v);
    nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // scaled ramp: fraction s of maximum m, FFFFh giving m itself
  function automatic [31:0] scl(input logic [31:0] m, input logic [15:0] s);
    logic [47:0] p;
    p   = {16'h0000, m} * s + m;
    scl = (s == 16'h0000) ? 32'h0 : p[47:16];
  endfunction

  // one parameter request, answer noted for the monitor
  task automatic par(input logic wr, input logic [15:0] n,
                     input logic [5:0] s, input logic [31:0] v,
                     input logic [32:0] e);
    @(posedge clk);
    par_wr           <= wr;
    par_rd           <= !wr;
    parameter_number <= n;
    par_subindex     <= s;
    par_wdata        <= v;
    pq.push_back(e);
    @(posedge clk);
    par_wr <= 1'b0;
    par_rd <= 1'b0;
  endtask

  // start or step a motion command, latched target then changed
  task automatic cmd(input logic adv, input logic [10:0] h,
                     input logic [31:0] ea, input logic [31:0] ed);
    @(posedge clk);
    if (adv) record_advance <= 1'b1;
    else motion_start <= 1'b1;
    cq.push_back({h, want_target, want_velocity, ea, ed});
    @(posedge clk);
    record_advance <= 1'b0;
    motion_start   <= 1'b0;
    want_target    <= ~want_target;
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // monitor: each answer takes the oldest note
  always @(negedge clk) begin
    if (!rst && par_ack === 1'b1) begin
      pe = pq.pop_front();
      `CHK({par_err, par_rdata}, pe)
    end
    if (!rst && cmd_valid === 1'b1) begin
      ce = cq.pop_front();
      `CHK({cmd_direct, cmd_record, cmd_kind, cmd_range_mode},
           ce[138:128])
      if (ce[138])
        `CHK({cmd_target, cmd_velocity, cmd_accel, cmd_decel},
             ce[127:0])
    end
  end

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      give_verdict;
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    par(1'b1, 16'h2533, 6'h00, 32'h1, {1'b1, 32'h0});
    par(1'b1, 16'h2400, 6'h00, 32'h4, {1'b1, 32'h0});
    par(1'b1, 16'h2538, 6'h00, 32'h0001_0001, {1'b1, 32'h0});
    par(1'b1, 16'h2610, 6'h05, 32'h2, {1'b1, 32'h0});
    foreach (pn[i]) par(1'b0, pn[i], 6'h3F, 32'h0, 33'h0);
    for (int r = 0; r < 4; r++) begin
      par(1'b1, 16'h2400, 6'h00, r, 33'h0);
      par(1'b0, 16'h2400, 6'h00, 32'h0, {1'b0, r});
    end
    // direct entry with every range and mode pairing
    rnd = nx(rnd);
    max_accel   <= {rnd, 16'h0F5A};
    max_decel   <= {~rnd, 16'hA5C3};
    want_direct <= 1'b1;
    repeat (4) @(posedge clk);
    par(1'b0, 16'h2533, 6'h00, 32'h0, {1'b0, 32'h0000_8000});
    for (int i = 0; i < 8; i++) begin
      rnd = nx(rnd);
      a = (i == 0) ? 16'hFFFF : rnd;
      rnd = nx(rnd);
      d = (i == 1) ? 16'h0000 : rnd;
      k = (i < 2) ? 2'(i % 2) : 2'(2 + i % 2);
      par(1'b1, 16'h2400, 6'h00, i / 2, 33'h0);
      par(1'b1, 16'h2538, 6'h00, i % 2, 33'h0);
      par(1'b1, 16'h2536, 6'h00, {16'h0000, a}, 33'h0);
      par(1'b1, 16'h2537, 6'h00, {16'h0000, d}, 33'h0);
      want_target   <= {rnd, ~rnd};
      want_velocity <= {~rnd, rnd};
      cmd(1'b0, {1'b1, 6'h00, k, 2'(i / 2)}, scl(max_accel, a),
          scl(max_decel, d));
    end
    // leaving direct entry while a command is busy
    cmd_busy    <= 1'b1;
    want_direct <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk) `CHK(cmd_reject, 1'b1)
    @(posedge clk);
    cmd_busy     <= 1'b0;
    // program submode from the record table
    prog_running <= 1'b1;
    exec_record  <= 10'h3BF;
    want_record  <= 6'h03;
    par(1'b1, 16'h2610, 6'h3F, 32'h1, 33'h0);
    par(1'b0, 16'h2610, 6'h3F, 32'h0, {1'b0, 32'h1});
    par(1'b1, 16'h2400, 6'h00, 32'h2, 33'h0);
    cmd(1'b0, {1'b0, 6'h03, 2'h2, 2'h2}, 32'h0, 32'h0);
    par(1'b1, 16'h2400, 6'h00, 32'h0, 33'h0);
    cmd(1'b1, {1'b0, 6'h3F, 2'h1, 2'h2}, 32'h0, 32'h0);
    par(1'b0, 16'h2533, 6'h00, 32'h0, {1'b0, 32'h0000_003F});
    // direct entry asked for while the program runs
    want_direct <= 1'b1;
    repeat (5) @(posedge clk);
    par(1'b0, 16'h2533, 6'h00, 32'h0, {1'b0, 32'h0000_003F});
    prog_terminate <= 1'b1;
    @(posedge clk);
    prog_terminate <= 1'b0;
    prog_running   <= 1'b0;
    repeat (3) @(posedge clk);
    par(1'b0, 16'h2533, 6'h00, 32'h0, {1'b0, 32'h0000_8000});
    repeat (3) @(posedge clk);
    `CHK(pq.size() + cq.size(), 0)
    give_verdict;
  end
endmodule

bind mrs_regs mrs_regs_checker u_mrs_regs_checker (
  .clk(clk), .rst(rst), .par_wr(par_wr),
  .parameter_number(parameter_number), .par_wdata(par_wdata),
  .par_ack(par_ack), .par_err(par_err),
  .record_selection_word(record_selection_word),
  .active_record_status(active_record_status),
  .prog_running(prog_running), .prog_terminate(prog_terminate),
  .exec_record(exec_record), .motion_start(motion_start),
  .cmd_busy(cmd_busy), .cmd_valid(cmd_valid), .cmd_direct(cmd_direct),
  .cmd_record(cmd_record), .cmd_reject(cmd_reject)
);
